// ===== design/piu_core.sv
`timescale 1ns/10ps
// interrupt sequencer: samples requests, runs the context switch of up to six states, each memory state waiting for mem_ack
module piu_core (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        interrupt_request,
  input  wire logic [3:0]  level_code_lines,   // bit 3 is the first code line
  input  wire logic        instr_boundary,     // pulse: current instruction finished
  input  wire logic        illegal_opcode,     // level: undefined opcode at boundary
  input  wire logic        coprocessor_present,
  input  wire logic        hold_request,
  input  wire logic        ctx_restored,       // pulse: restore and bus regain done
  input  wire logic        mem_ack,            // pulse: one word transfer finished
  input  wire logic [15:0] mem_rdata,
  input  wire logic [15:0] cur_wp,
  input  wire logic [15:0] cur_pc,
  input  wire logic [15:0] cur_st,
  output logic             interrupt_acknowledge,
  output logic             alternate_map_enable,
  output logic             hold_grant,
  output logic             mem_req,
  output logic             mem_write,
  output logic [15:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  output logic             ctx_load,           // pulse: new wp/pc/st valid
  output logic [15:0]      new_wp,
  output logic [15:0]      new_pc,
  output logic [15:0]      new_st,
  output logic             busy
);
  piu_pkg::piu_state_t state_q;
  piu_pkg::piu_src_t   src_q;
  piu_pkg::piu_src_t   sel_src;
  logic [3:0]          lvl_q;
  logic [3:0]          sel_lvl;
  logic                sel_take;
  logic [15:0]         old_wp_q;
  logic [15:0]         old_pc_q;
  logic [15:0]         old_st_q;
  logic [15:0]         vec_wp_q;
  logic [15:0]         vec_pc_q;
  logic [15:0]         st_next;
  logic [15:0]         vec_base;
  logic                held;
  logic                hold_ack_q;
  logic                inhibit_q;
  logic                reset_pend_q;
  logic                trap_pend_q;
  logic                ctx_load_q;

  // ---------------------------------------------------------------
  // source selection
  // ---------------------------------------------------------------
  // inhibit after a switch masks external and overflow requests; reset and the opcode trap are not masked
  piu_sel u_sel (
    .ext_req    (interrupt_request && !inhibit_q),                      // [RULE9]
    .ext_code   (level_code_lines),                                     // [RULE18]
    .mask       (cur_st[piu_pkg::MASK_LSB +: piu_pkg::LVL_W]),
    .ovf_flag   (cur_st[piu_pkg::OVF_BIT] && !inhibit_q),
    .ovf_en     (cur_st[piu_pkg::OVF_EN_BIT]),                          // [RULE16]
    .illegal_op (illegal_opcode && !coprocessor_present),               // [RULE15]
    .take       (sel_take),
    .level      (sel_lvl),
    .src        (sel_src)
  );

  assign held     = hold_request || coprocessor_present;
  assign vec_base = {12'h000, lvl_q} * piu_pkg::VEC_STRIDE;             // [RULE5]

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q      <= piu_pkg::PIU_RUN;
      src_q        <= piu_pkg::PIU_SRC_RESET;
      lvl_q        <= piu_pkg::LVL_RESET;
      reset_pend_q <= 1'b1;
    end else begin
      unique case (state_q)
        piu_pkg::PIU_RUN: begin
          if (reset_pend_q) begin
            // level 0 ignores the mask entirely
            state_q      <= piu_pkg::PIU_RD_WP;                         // [RULE2] [RULE19]
            src_q        <= piu_pkg::PIU_SRC_RESET;
            lvl_q        <= piu_pkg::LVL_RESET;
            reset_pend_q <= 1'b0;
          end else if (instr_boundary && illegal_opcode && coprocessor_present) begin
            state_q <= piu_pkg::PIU_HOLD;
          end else if (instr_boundary && sel_take && !held) begin
            state_q <= piu_pkg::PIU_RD_WP;                              // [RULE4] [RULE11] [RULE22]
            src_q   <= sel_src;
            lvl_q   <= sel_lvl;
          end else if (held) begin
            state_q <= piu_pkg::PIU_HOLD;
          end
        end
        // bus given away; resume only after restore completes
        piu_pkg::PIU_HOLD: begin
          if (!held && ctx_restored)
            state_q <= piu_pkg::PIU_RUN;                                // [RULE14]
        end
        piu_pkg::PIU_RD_WP: if (mem_ack) state_q <= piu_pkg::PIU_RD_PC;
        piu_pkg::PIU_RD_PC: begin
          if (mem_ack)
            state_q <= (src_q == piu_pkg::PIU_SRC_RESET) ? piu_pkg::PIU_FIRST : piu_pkg::PIU_WR_WP;
        end
        piu_pkg::PIU_WR_WP: if (mem_ack) state_q <= piu_pkg::PIU_WR_PC; // [RULE7]
        piu_pkg::PIU_WR_PC: if (mem_ack) state_q <= piu_pkg::PIU_WR_ST;
        piu_pkg::PIU_WR_ST: if (mem_ack) state_q <= piu_pkg::PIU_FIRST;
        piu_pkg::PIU_FIRST: state_q <= piu_pkg::PIU_RUN;
        default: state_q <= piu_pkg::PIU_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // context capture
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      old_wp_q <= piu_pkg::WORD_ZERO;
      old_pc_q <= piu_pkg::WORD_ZERO;
      old_st_q <= piu_pkg::WORD_ZERO;
      vec_wp_q <= piu_pkg::WORD_ZERO;
      vec_pc_q <= piu_pkg::WORD_ZERO;
    end else begin
      if (state_q == piu_pkg::PIU_RUN) begin
        old_wp_q <= cur_wp;
        old_pc_q <= cur_pc;
        old_st_q <= cur_st;
      end
      if (state_q == piu_pkg::PIU_RD_WP && mem_ack)
        vec_wp_q <= mem_rdata;
      if (state_q == piu_pkg::PIU_RD_PC && mem_ack)
        vec_pc_q <= mem_rdata;
    end
  end

  // ---------------------------------------------------------------
  // new status word
  // ---------------------------------------------------------------
  always_comb begin
    st_next = old_st_q;
    unique case (src_q)
      piu_pkg::PIU_SRC_RESET: st_next = piu_pkg::ST_RESET;              // [RULE19]
      piu_pkg::PIU_SRC_TRAP: begin
        st_next[piu_pkg::CLR_MSB:piu_pkg::CLR_LSB] = 5'h00;             // [RULE21]
      end
      piu_pkg::PIU_SRC_OVF: begin
        st_next[piu_pkg::CLR_MSB:piu_pkg::CLR_LSB] = 5'h00;
        st_next[piu_pkg::MASK_LSB +: piu_pkg::LVL_W] = piu_pkg::MASK_OVF; // [RULE20]
      end
      piu_pkg::PIU_SRC_EXT: begin
        st_next[piu_pkg::CLR_MSB:piu_pkg::CLR_LSB] = 5'h00;             // [RULE8]
        st_next[piu_pkg::MASK_LSB +: piu_pkg::LVL_W] = lvl_q - 4'h1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // memory port
  // ---------------------------------------------------------------
  // wp word first, then pc word, at the level's vector pair
  always_comb begin
    mem_req   = 1'b1;
    mem_write = 1'b0;
    mem_addr  = piu_pkg::WORD_ZERO;
    mem_wdata = piu_pkg::WORD_ZERO;
    unique case (state_q)
      piu_pkg::PIU_RD_WP: mem_addr = vec_base;                          // [RULE5]
      piu_pkg::PIU_RD_PC: mem_addr = vec_base + piu_pkg::PC_OFFSET;
      piu_pkg::PIU_WR_WP: begin
        mem_write = 1'b1;
        mem_addr  = vec_wp_q + piu_pkg::SLOT_WP;                        // [RULE7]
        mem_wdata = old_wp_q;
      end
      piu_pkg::PIU_WR_PC: begin
        mem_write = 1'b1;
        mem_addr  = vec_wp_q + piu_pkg::SLOT_PC;
        mem_wdata = old_pc_q;
      end
      piu_pkg::PIU_WR_ST: begin
        mem_write = 1'b1;
        mem_addr  = vec_wp_q + piu_pkg::SLOT_ST;
        mem_wdata = old_st_q;
      end
      default: mem_req = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // context load and inhibit
  // ---------------------------------------------------------------
  // inhibit covers the first routine instruction; reset never blocked
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctx_load_q <= 1'b0;
      inhibit_q  <= 1'b0;
      new_wp     <= piu_pkg::WORD_ZERO;
      new_pc     <= piu_pkg::WORD_ZERO;
      new_st     <= piu_pkg::WORD_ZERO;
    end else begin
      ctx_load_q <= (state_q == piu_pkg::PIU_FIRST);
      if (state_q == piu_pkg::PIU_FIRST) begin
        new_wp    <= vec_wp_q;
        new_pc    <= vec_pc_q;
        new_st    <= st_next;
        inhibit_q <= 1'b1;                                              // [RULE9]
      end else if (instr_boundary && state_q == piu_pkg::PIU_RUN) begin
        inhibit_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // acknowledge, map enable, hold grant
  // ---------------------------------------------------------------
  // held-state ack is sticky until the hold cause drops
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hold_ack_q <= 1'b0;
    end else if (!held) begin
      hold_ack_q <= 1'b0;                                               // [RULE13]
    end else if (interrupt_request
                 && level_code_lines <= cur_st[piu_pkg::MASK_LSB +: piu_pkg::LVL_W]) begin
      hold_ack_q <= 1'b1;                                               // [RULE12] [RULE14]
    end
  end

  // keeps busy high for one cycle after a held-state ack in hold
  always_ff @(posedge mclk) begin
    if (sys_rst)
      trap_pend_q <= 1'b0;
    else
      trap_pend_q <= hold_ack_q && state_q == piu_pkg::PIU_HOLD;
  end

  assign interrupt_acknowledge = (state_q == piu_pkg::PIU_RD_PC && mem_ack)
                                 || (hold_ack_q && held);               // [RULE6] [RULE13]
  assign alternate_map_enable  = (state_q != piu_pkg::PIU_RUN) && (state_q != piu_pkg::PIU_HOLD); // [RULE6]
  assign hold_grant            = (state_q == piu_pkg::PIU_HOLD) && held;
  assign ctx_load              = ctx_load_q;
  assign busy                  = (state_q != piu_pkg::PIU_RUN) || trap_pend_q;
endmodule

// ===== design/piu_pkg.sv
// Behaviour
// (RULE1) sixteen levels, level 0 highest priority, level 15 lowest
// (RULE2) level 0 is reset and is serviced regardless of the mask
// (RULE3) one request line plus four code lines compared against status mask bits 12..15
// (RULE4) accept when code <= mask, switch after the current instruction ends
// (RULE5) vector pair fetched at level times four, 0x04 up to 0x3C
// (RULE6) during the switch drive alternate map enable high and raise acknowledge
// (RULE7) old workspace, counter, status stored to registers 13, 14, 15 in order
// (RULE8) servicing clears status bits 7..11 and sets mask to level minus one
// (RULE9) no new interrupt until the first routine instruction has executed
// (RULE10) requester holds request and code until the routine clears it
// (RULE11) higher priority arrival inside a routine causes a nested switch
// (RULE12) during hold or coprocessor present keep sampling and acknowledge qualified requests
// (RULE13) that acknowledge stays until hold or coprocessor present is released
// (RULE14) pending request under chaining coprocessor serviced after release, restore and bus regain
// (RULE15) undefined opcode without coprocessor present traps through the level 2 vector
// (RULE16) overflow interrupt uses level 2, enabled by status bit 10
// (RULE17) illegal opcode trap uses level 2 and ignores the mask
// (RULE18) requester encodes level n as binary n, first code line most significant
// (RULE19) reset release fetches vectors at words 0 and 2, acknowledges, clears status
// (RULE20) servicing overflow forces mask to one
// (RULE21) undefined opcode trap leaves the mask unchanged
// (RULE22) unsigned four bit compare, re-evaluated at every instruction boundary
package piu_pkg;
  // ---------------------------------------------------------------
  // widths and field positions
  // ---------------------------------------------------------------
  localparam int          LVL_W       = 4;
  localparam int          ST_W        = 16;
  localparam int          ADDR_W      = 16;
  localparam int          MASK_LSB    = 12;
  localparam int          CLR_LSB     = 7;
  localparam int          CLR_MSB     = 11;
  localparam int          OVF_EN_BIT  = 10;
  localparam int          OVF_BIT     = 4;
  // ---------------------------------------------------------------
  // levels, vectors, workspace slots
  // ---------------------------------------------------------------
  localparam logic [3:0]  LVL_RESET   = 4'h0;
  localparam logic [3:0]  LVL_TRAP    = 4'h2;
  localparam logic [3:0]  MASK_OVF    = 4'h1;
  localparam logic [15:0] VEC_STRIDE  = 16'h0004;
  localparam logic [15:0] PC_OFFSET   = 16'h0002;
  localparam logic [15:0] SLOT_WP     = 16'h001A; // register 13 times two
  localparam logic [15:0] SLOT_PC     = 16'h001C; // register 14 times two
  localparam logic [15:0] SLOT_ST     = 16'h001E; // register 15 times two
  localparam logic [15:0] ST_RESET    = 16'h0000;
  localparam logic [15:0] WORD_ZERO   = 16'h0000;

  // context-switch sequencer
  typedef enum logic [3:0] {
    PIU_RUN, PIU_RD_WP, PIU_RD_PC, PIU_WR_WP, PIU_WR_PC, PIU_WR_ST, PIU_FIRST, PIU_HOLD
  } piu_state_t;

  // kind of event being serviced
  typedef enum logic [1:0] {
    PIU_SRC_RESET, PIU_SRC_EXT, PIU_SRC_OVF, PIU_SRC_TRAP
  } piu_src_t;
endpackage

// ===== design/piu_sel.sv
`timescale 1ns/10ps
// picks the winning source at an instruction boundary
module piu_sel (
  input  wire logic       ext_req,
  input  wire logic [3:0] ext_code,
  input  wire logic [3:0] mask,
  input  wire logic       ovf_flag,
  input  wire logic       ovf_en,
  input  wire logic       illegal_op,
  output logic            take,
  output logic [3:0]      level,
  output piu_pkg::piu_src_t src
);
  logic ext_ok;
  logic ovf_ok;

  // ---------------------------------------------------------------
  // qualification
  // ---------------------------------------------------------------
  // plain unsigned compare, no signed tricks
  assign ext_ok = ext_req && (ext_code <= mask);                       // [RULE3] [RULE4] [RULE22]
  assign ovf_ok = ovf_flag && ovf_en && (piu_pkg::LVL_TRAP <= mask);   // [RULE16]

  // trap overrides any level; level 0/1 override overflow
  always_comb begin
    take  = 1'b0;
    level = piu_pkg::LVL_TRAP;
    src   = piu_pkg::PIU_SRC_EXT;
    if (illegal_op) begin
      take  = 1'b1;                                                    // [RULE17]
      src   = piu_pkg::PIU_SRC_TRAP;
    end else if (ext_ok && (!ovf_ok || ext_code < piu_pkg::LVL_TRAP)) begin
      take  = 1'b1;                                                    // [RULE1]
      level = ext_code;
    end else if (ovf_ok) begin
      take  = 1'b1;
      src   = piu_pkg::PIU_SRC_OVF;
    end
  end
endmodule

// ===== testbench/piu_core_props.sv
`timescale 1ns/10ps
// ----------------------------------------
// sequencer checks at the core's ports
// ----------------------------------------
module piu_core_props (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        interrupt_request,
  input wire logic [3:0]  level_code_lines,
  input wire logic        instr_boundary,
  input wire logic        illegal_opcode,
  input wire logic        coprocessor_present,
  input wire logic        hold_request,
  input wire logic        mem_ack,
  input wire logic [15:0] cur_st,
  input wire logic        interrupt_acknowledge,
  input wire logic        alternate_map_enable,
  input wire logic        hold_grant,
  input wire logic        mem_req,
  input wire logic        mem_write,
  input wire logic [15:0] mem_addr,
  input wire logic        ctx_load,
  input wire logic [15:0] new_st,
  input wire logic        busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic held;
  // bus surrendered to a holder or the coprocessor
  assign held = hold_request || coprocessor_present;
  a_reset_vec: assert property ($fell(sys_rst) |=> mem_req && !mem_write && mem_addr == 16'h0000)
    else $error("no workspace vector read after reset");
  a_map_switch: assert property (mem_req |-> alternate_map_enable)
    else $error("map enable low during switch access");
  a_ack_pc: assert property (interrupt_acknowledge && !held |-> mem_req && mem_ack && !mem_write && mem_addr[1])
    else $error("acknowledge outside the vector counter read");
  a_req_stable: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_write))
    else $error("access changed before completion");
  a_no_take: assert property (instr_boundary && !busy && !held && interrupt_request && !illegal_opcode
    && level_code_lines > cur_st[15:12] && !(cur_st[4] && cur_st[10]) |=> !mem_req)
    else $error("request above mask was taken");
  a_ctx_quiet: assert property (ctx_load |=> !ctx_load && !mem_req)
    else $error("activity right after context load");
  a_st_clear: assert property (ctx_load |-> new_st[11:7] == 5'h00)
    else $error("status bits 7 to 11 not cleared");
  a_grant_quiet: assert property (hold_grant |-> !mem_req)
    else $error("bus access while granted away");
  a_ack_stays: assert property (interrupt_acknowledge && held && !mem_req |=> interrupt_acknowledge || !held)
    else $error("held acknowledge dropped early");
  a_ack_given: assert property (mem_req && mem_ack && !mem_write && mem_addr[1] |-> interrupt_acknowledge)
    else $error("no acknowledge with the vector counter read");
  a_held_ack: assert property ((held && interrupt_request && level_code_lines <= cur_st[15:12])[*3]
    |-> ##[0:10] interrupt_acknowledge)
    else $error("no acknowledge for request while held");
endmodule

bind piu_core piu_core_props i_piu_core_props (
  .mclk                  (mclk),
  .sys_rst               (sys_rst),
  .interrupt_request     (interrupt_request),
  .level_code_lines      (level_code_lines),
  .instr_boundary        (instr_boundary),
  .illegal_opcode        (illegal_opcode),
  .coprocessor_present   (coprocessor_present),
  .hold_request          (hold_request),
  .mem_ack               (mem_ack),
  .cur_st                (cur_st),
  .interrupt_acknowledge (interrupt_acknowledge),
  .alternate_map_enable  (alternate_map_enable),
  .hold_grant            (hold_grant),
  .mem_req               (mem_req),
  .mem_write             (mem_write),
  .mem_addr              (mem_addr),
  .ctx_load              (ctx_load),
  .new_st                (new_st),
  .busy                  (busy)
);

// ===== testbench/piu_mem_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// word memory answering the switch bus
// ----------------------------------------
module piu_mem_model (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [1:0]  lat,
  input  wire logic        mem_req,
  input  wire logic        mem_write,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata
);
  logic [15:0] mem [0:511];
  logic [1:0]  wait_q;
  // vector pairs: level l points at workspace 0x40 + 32*l
  initial begin
    mem_ack   = 1'b0;
    mem_rdata = 16'h5A5A;
    for (int l = 0; l < 16; l++) begin
      mem[2*l]   = 16'h0040 + 16'(l * 32);
      mem[2*l+1] = 16'h1000 + 16'(l);
    end
  end
  // one word after lat idle cycles; idle data toggles so stale reads show
  always @(posedge mclk) begin
    mem_ack   <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (sys_rst) begin
      wait_q <= 2'h0;
    end else if (mem_req && !mem_ack) begin
      if (wait_q == lat) begin
        mem_ack <= 1'b1;
        wait_q  <= 2'h0;
        if (mem_write) mem[mem_addr[9:1]] <= mem_wdata;
        else mem_rdata <= mem[mem_addr[9:1]];
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule

// ===== testbench/tb.sv
`timescale 1ns/10ps
module tb;
  logic        mclk, sys_rst, interrupt_request, instr_boundary, illegal_opcode;
  logic        coprocessor_present, hold_request, ctx_restored, mem_ack, ctx_load, busy;
  logic        interrupt_acknowledge, alternate_map_enable, hold_grant, mem_req, mem_write;
  logic [3:0]  level_code_lines;
  logic [1:0]  lat;
  logic [15:0] mem_rdata, cur_wp, cur_pc, cur_st, mem_addr, mem_wdata, new_wp, new_pc, new_st;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cycles     = 0;

  piu_core i_piu_core (
    .mclk                  (mclk),
    .sys_rst               (sys_rst),
    .interrupt_request     (interrupt_request),
    .level_code_lines      (level_code_lines),
    .instr_boundary        (instr_boundary),
    .illegal_opcode        (illegal_opcode),
    .coprocessor_present   (coprocessor_present),
    .hold_request          (hold_request),
    .ctx_restored          (ctx_restored),
    .mem_ack               (mem_ack),
    .mem_rdata             (mem_rdata),
    .cur_wp                (cur_wp),
    .cur_pc                (cur_pc),
    .cur_st                (cur_st),
    .interrupt_acknowledge (interrupt_acknowledge),
    .alternate_map_enable  (alternate_map_enable),
    .hold_grant            (hold_grant),
    .mem_req               (mem_req),
    .mem_write             (mem_write),
    .mem_addr              (mem_addr),
    .mem_wdata             (mem_wdata),
    .ctx_load              (ctx_load),
    .new_wp                (new_wp),
    .new_pc                (new_pc),
    .new_st                (new_st),
    .busy                  (busy)
  );
  piu_mem_model i_piu_mem_model (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .lat       (lat),
    .mem_req   (mem_req),
    .mem_write (mem_write),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_ack   (mem_ack),
    .mem_rdata (mem_rdata)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic conclude();
    $display("mismatches %0d compares %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // inputs move 1 ns after the edge so no race with the design
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic bnd();
    instr_boundary = 1'b1;
    tick(1);
    instr_boundary = 1'b0;
    // a quiet cycle keeps back-to-back boundaries apart
    tick(1);
  endtask
  task automatic wctx();
    for (int i = 0; i < 300 && ctx_load !== 1'b1; i++) tick(1);
    chk({15'h0, ctx_load}, 16'h0001);
  endtask
  function automatic logic [15:0] rd(input logic [15:0] a);
    return i_piu_mem_model.mem[a[9:1]];
  endfunction
  // boundary, full switch, then the routine's first instruction
  task automatic serve(input logic [3:0] l, input logic [15:0] est);
    logic [15:0] w;
    w = 16'h0040 + {7'h00, l, 5'h00};
    bnd();
    wctx();
    chk(new_wp, w);
    chk(new_pc, 16'h1000 + {12'h000, l});
    chk(new_st, est);
    chk(rd(w + 16'h001A), cur_wp);
    chk(rd(w + 16'h001C), cur_pc);
    chk(rd(w + 16'h001E), cur_st);
    interrupt_request = 1'b0; // requester clears once serviced
    illegal_opcode    = 1'b0;
    cur_st            = est;
    bnd();
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // hang guard at 20000 cycles, the run needs under a thousand
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      conclude();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {sys_rst, interrupt_request, instr_boundary, illegal_opcode} = 4'h8;
    {coprocessor_present, hold_request, ctx_restored} = 3'h0;
    level_code_lines = 4'h0;
    lat = 2'h0;
    {cur_wp, cur_pc, cur_st} = 48'h0;
    tick(4);
    sys_rst = 1'b0;
    wctx();
    chk(new_wp, 16'h0040);
    chk(new_pc, 16'h1000);
    chk(new_st, 16'h0000);
    bnd();
    // every external level: one above the mask refused (levels 1 to 14 only), equal taken
    for (int l = 1; l < 16; l++) begin
      cur_wp = 16'hA000 + 16'(l);
      cur_pc = 16'hB000 + 16'(l);
      cur_st = {l[3:0], 12'hBEF};
      lat = 2'(l % 3);
      interrupt_request = 1'b1;
      if (l < 15) begin
        level_code_lines = l[3:0] + 4'h1; // binary level code
        bnd();
        tick(3);
        chk({15'h0, mem_req}, 16'h0000);
      end
      level_code_lines = l[3:0];
      serve(l[3:0], {l[3:0] - 4'h1, 12'h06F});
    end
    cur_st = 16'h0BEF;
    illegal_opcode = 1'b1;
    serve(4'h2, 16'h006F);
    cur_st = 16'h5010;
    bnd();
    tick(3);
    chk({15'h0, mem_req}, 16'h0000);
    cur_st = 16'h5410;
    serve(4'h2, 16'h1010);
    // coprocessor takes an undefined opcode, request arrives meanwhile
    cur_st = 16'h5000;
    illegal_opcode = 1'b1;
    coprocessor_present = 1'b1;
    bnd();
    illegal_opcode = 1'b0;
    interrupt_request = 1'b1;
    level_code_lines = 4'h3;
    tick(10);
    chk({15'h0, hold_grant}, 16'h0001);
    chk({15'h0, interrupt_acknowledge}, 16'h0001);
    tick(5);
    chk({15'h0, interrupt_acknowledge}, 16'h0001);
    coprocessor_present = 1'b0;
    tick(3);
    chk({15'h0, mem_req}, 16'h0000);
    chk({15'h0, interrupt_acknowledge}, 16'h0000);
    ctx_restored = 1'b1;
    tick(1);
    ctx_restored = 1'b0;
    serve(4'h3, 16'h2000);
    // higher level arrives inside the level 3 routine
    interrupt_request = 1'b1;
    level_code_lines  = 4'h1;
    serve(4'h1, 16'h0000);
    // plain bus hold: request acknowledged while the bus is away
    cur_st            = 16'h3000;
    hold_request      = 1'b1;
    interrupt_request = 1'b1;
    level_code_lines  = 4'h2;
    tick(3);
    chk({15'h0, hold_grant}, 16'h0001);
    chk({15'h0, interrupt_acknowledge}, 16'h0001);
    hold_request = 1'b0;
    tick(1);
    chk({15'h0, interrupt_acknowledge}, 16'h0000);
    chk({15'h0, mem_req}, 16'h0000);
    ctx_restored = 1'b1;
    tick(1);
    ctx_restored = 1'b0;
    serve(4'h2, 16'h1000);
    // reset in mid-run restarts level 0 whatever the mask
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    wctx();
    chk(new_wp, 16'h0040);
    chk(new_pc, 16'h1000);
    chk(new_st, 16'h0000);
    conclude();
  end
endmodule
